// >>> shared/bmmd_defines.vh
// Constants shared by the branch, copy and product decode block.
`ifndef BMMD_DEFINES_VH
`define BMMD_DEFINES_VH
`define OP_NONE 8'h00
`define OP_JUMP_LONG 8'h02
`define OP_CALL_LONG 8'h12
`define OP_BR_ZERO 8'h60
`define OP_A_IMM 8'h74
`define OP_DIR_IMM 8'h75
`define OP_CODE_PC 8'h83
`define OP_DIR_DIR 8'h85
`define OP_DP_IMM 8'h90
`define OP_BIT_C 8'h92
`define OP_CODE_DP 8'h93
`define OP_C_BIT 8'hA2
`define OP_PRODUCT 8'hA4
`define OP_XR_DP 8'hE0
`define OP_A_DIR 8'hE5
`define OP_XW_DP 8'hF0
`define OP_DIR_A 8'hF5
`define G_A_RN 5'h1D
`define G_RN_A 5'h1F
`define G_RN_IMM 5'h0F
`define G_RN_DIR 5'h15
`define G_DIR_RN 5'h11
`define P_A_IND 7'h73
`define P_IND_A 7'h7B
`define P_IND_IMM 7'h3B
`define P_IND_DIR 7'h53
`define P_DIR_IND 7'h43
`define P_XW_RI 7'h79
`define P_XR_RI 7'h71
`define SFR_SP 8'h81
`define SFR_DPL 8'h82
`define SFR_DPH 8'h83
`define SFR_HI_PORT 8'hA0
`define SFR_PSW 8'hD0
`define SFR_ACC 8'hE0
`define SFR_B 8'hF0
`define PSW_CY 7
`define PSW_WIDE 2
`define PSW_RS_HI 4
`define PSW_RS_LO 3
`define BIT_RAM_HI 4'h2
`define SP_RST 8'h07
`define HI_PORT_RST 8'hFF
`define LO_PORT_RST 8'hFF
`define MC_CLKS_DEF 8
`define XSTRB_CLKS 3'h4
`endif

// >>> hdl/bmmd_prod.v
// Shift and add unsigned multiplier used by the byte product instruction.
`timescale 1ns/100ps
`default_nettype none
module bmmd_prod #(
    parameter W = 8
) (
    input wire clk,
    input wire sys_rst,
    input wire start,
    input wire [W-1:0] mcand,
    input wire [W-1:0] mplier,
    output wire [2*W-1:0] prod,
    output wire done
);
    reg [2*W-1:0] sum_r;
    reg [2*W-1:0] mc_r;
    reg [W-1:0] mp_r;
    reg [W:0] left_r;
    reg done_r;

    assign prod = sum_r;
    assign done = done_r;

    // One multiplier bit is consumed per clock; done pulses once after the last.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sum_r <= {2*W{1'b0}};
            mc_r <= {2*W{1'b0}};
            mp_r <= {W{1'b0}};
            left_r <= {(W+1){1'b0}};
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (start) begin
                sum_r <= {2*W{1'b0}};
                mc_r <= {{W{1'b0}}, mcand};
                mp_r <= mplier;
                left_r <= {1'b1, {W{1'b0}}};
            end else if (left_r != {(W+1){1'b0}}) begin
                if (mp_r[0]) begin
                    sum_r <= sum_r + mc_r;
                end
                mc_r <= {mc_r[2*W-2:0], 1'b0};
                mp_r <= {1'b0, mp_r[W-1:1]};
                left_r <= {1'b0, left_r[W:1]};
                done_r <= left_r[0];
            end
        end
    end
endmodule
`default_nettype wire

// >>> hdl/bmmd_core.v
// Fetch, decode and execute engine for the branch, copy, table read and product instructions.
`timescale 1ns/100ps
`default_nettype none
`include "bmmd_defines.vh"
module bmmd_core #(
    parameter MC_CLKS = `MC_CLKS_DEF
) (
    input wire clk,
    input wire sys_rst,
    output wire [15:0] code_addr,
    input wire [7:0] code_data,
    input wire [7:0] lo_port_in,
    output wire [7:0] lo_port_out,
    output wire lo_port_oe_n,
    output wire [7:0] hi_port_out,
    output wire addr_latch,
    output wire ext_rd_n,
    output wire ext_wr_n,
    output wire [15:0] pc_out,
    output wire [7:0] acc_out
);
    localparam [3:0] S_FA = 4'h0;
    localparam [3:0] S_FD = 4'h1;
    localparam [3:0] S_EX = 4'h2;
    localparam [3:0] S_PU1 = 4'h3;
    localparam [3:0] S_PU2 = 4'h4;
    localparam [3:0] S_CD = 4'h5;
    localparam [3:0] S_MU = 4'h6;
    localparam [3:0] S_XS = 4'h7;
    localparam [3:0] S_XE = 4'h8;
    localparam [3:0] S_WT = 4'h9;
    localparam [7:0] MCW = MC_CLKS;

    reg [7:0] iram [0:255];
    reg [3:0] state_r;
    reg [15:0] pc_r;
    reg [15:0] code_addr_r;
    reg [7:0] ir_r;
    reg [7:0] op1_r;
    reg [7:0] op2_r;
    reg [1:0] idx_r;
    reg [7:0] cnt_r;
    reg [2:0] xcnt_r;
    reg [7:0] acc_r;
    reg [7:0] b_r;
    reg [7:0] psw_r;
    reg [7:0] sp_r;
    reg [15:0] dp_r;
    reg [7:0] lo_port_out_r;
    reg lo_port_oe_n_r;
    reg [7:0] hi_port_out_r;
    reg addr_latch_r;
    reg ext_rd_n_r;
    reg ext_wr_n_r;
    reg [7:0] lo_s1_r;
    reg [7:0] lo_s2_r;
    reg prod_go_r;
    reg wr_go;
    reg wr_ind;
    reg [7:0] wr_addr;
    reg [7:0] wr_val;
    reg [7:0] sfr_val;
    wire [15:0] prod;
    wire prod_done;

    // Byte count of an instruction; undecoded opcodes run as one-byte idles.
    function [1:0] op_len;
        input [7:0] o;
        begin
            case (o)
                `OP_NONE, `OP_CODE_PC, `OP_CODE_DP, `OP_PRODUCT, `OP_XR_DP, `OP_XW_DP: op_len = 2'd1;
                `OP_JUMP_LONG, `OP_CALL_LONG, `OP_DIR_IMM, `OP_DIR_DIR, `OP_DP_IMM: op_len = 2'd3;
                `OP_BR_ZERO, `OP_A_IMM, `OP_A_DIR, `OP_DIR_A, `OP_C_BIT, `OP_BIT_C: op_len = 2'd2;
                default: begin
                    if (o[7:3] == `G_RN_IMM || o[7:3] == `G_RN_DIR || o[7:3] == `G_DIR_RN ||
                        o[7:1] == `P_IND_IMM || o[7:1] == `P_IND_DIR || o[7:1] == `P_DIR_IND) begin
                        op_len = 2'd2;
                    end else begin
                        op_len = 2'd1;
                    end
                end
            endcase
        end
    endfunction

    // Machine cycles an instruction occupies from its first fetch.
    function [2:0] op_cyc;
        input [7:0] o;
        begin
            case (o)
                `OP_PRODUCT: op_cyc = 3'd4;
                `OP_NONE, `OP_A_IMM, `OP_A_DIR, `OP_DIR_A, `OP_C_BIT, `OP_CODE_PC: op_cyc = 3'd1;
                default: begin
                    if (o[7:3] == `G_A_RN || o[7:3] == `G_RN_A || o[7:3] == `G_RN_IMM ||
                        o[7:1] == `P_A_IND || o[7:1] == `P_IND_A || o[7:1] == `P_IND_IMM) begin
                        op_cyc = 3'd1;
                    end else begin
                        op_cyc = 3'd2;
                    end
                end
            endcase
        end
    endfunction

    wire [1:0] fetch_len = (idx_r == 2'd0) ? op_len(code_data) : op_len(ir_r);
    wire [7:0] total_clks = {5'h00, op_cyc(ir_r)} * MCW;
    wire [1:0] bank = psw_r[`PSW_RS_HI:`PSW_RS_LO];
    wire [7:0] rn_addr = {3'b000, bank, ir_r[2:0]};
    wire [7:0] rn_val = iram[rn_addr];
    wire [7:0] ri_val = iram[{3'b000, bank, 2'b00, ir_r[0]}];
    wire [7:0] ind_val = iram[ri_val];
    wire is_bit = (ir_r == `OP_C_BIT) || (ir_r == `OP_BIT_C);
    wire [7:0] bit_byte = op1_r[7] ? {op1_r[7:3], 3'b000} : {`BIT_RAM_HI, op1_r[6:3]};
    wire [7:0] dir_addr = is_bit ? bit_byte : op1_r;
    wire [7:0] dir_val = dir_addr[7] ? sfr_val : iram[dir_addr];
    wire [7:0] bit_mask = 8'h01 << op1_r[2:0];
    wire cy = psw_r[`PSW_CY];
    wire x_dp = (ir_r == `OP_XR_DP) || (ir_r == `OP_XW_DP);
    wire x_wr = (ir_r == `OP_XW_DP) || (ir_r[7:1] == `P_XW_RI);
    wire x_any = x_dp || (ir_r[7:1] == `P_XW_RI) || (ir_r[7:1] == `P_XR_RI);
    wire ram_we = wr_go && (wr_ind || !wr_addr[7]);
    wire sfr_we = wr_go && !wr_ind && wr_addr[7];

    assign code_addr = code_addr_r;
    assign lo_port_out = lo_port_out_r;
    assign lo_port_oe_n = lo_port_oe_n_r;
    assign hi_port_out = hi_port_out_r;
    assign addr_latch = addr_latch_r;
    assign ext_rd_n = ext_rd_n_r;
    assign ext_wr_n = ext_wr_n_r;
    assign pc_out = pc_r;
    assign acc_out = acc_r;

    // Special function register read mux; unmapped addresses read as zero.
    always @* begin
        case (dir_addr)
            `SFR_ACC: sfr_val = acc_r;
            `SFR_B: sfr_val = b_r;
            `SFR_PSW: sfr_val = psw_r;
            `SFR_SP: sfr_val = sp_r;
            `SFR_DPL: sfr_val = dp_r[7:0];
            `SFR_DPH: sfr_val = dp_r[15:8];
            `SFR_HI_PORT: sfr_val = hi_port_out_r;
            default: sfr_val = 8'h00;
        endcase
    end

    // Single byte write port; indirect writes always land in internal RAM.
    always @* begin
        wr_go = 1'b1;
        wr_ind = 1'b0;
        wr_addr = `SFR_ACC;
        wr_val = 8'h00;
        if (state_r == S_EX) begin
            if (ir_r == `OP_A_IMM) begin
                wr_val = op1_r;
            end else if (ir_r == `OP_A_DIR) begin
                wr_val = dir_val;
            end else if (ir_r[7:1] == `P_A_IND) begin
                wr_val = ind_val;
            end else if (ir_r[7:3] == `G_A_RN) begin
                wr_val = rn_val;
            end else if (ir_r[7:1] == `P_IND_A) begin
                wr_ind = 1'b1;
                wr_addr = ri_val;
                wr_val = acc_r;
            end else if (ir_r[7:3] == `G_RN_A) begin
                wr_ind = 1'b1;
                wr_addr = rn_addr;
                wr_val = acc_r;
            end else if (ir_r == `OP_DIR_A) begin
                wr_addr = op1_r;
                wr_val = acc_r;
            end else if (ir_r == `OP_BIT_C) begin
                wr_addr = bit_byte;
                wr_val = (dir_val & ~bit_mask) | (cy ? bit_mask : 8'h00);
            end else if (ir_r[7:1] == `P_IND_IMM) begin
                wr_ind = 1'b1;
                wr_addr = ri_val;
                wr_val = op1_r;
            end else if (ir_r[7:3] == `G_RN_IMM) begin
                wr_ind = 1'b1;
                wr_addr = rn_addr;
                wr_val = op1_r;
            end else if (ir_r[7:1] == `P_IND_DIR) begin
                wr_ind = 1'b1;
                wr_addr = ri_val;
                wr_val = dir_val;
            end else if (ir_r[7:3] == `G_RN_DIR) begin
                wr_ind = 1'b1;
                wr_addr = rn_addr;
                wr_val = dir_val;
            end else if (ir_r == `OP_DIR_IMM) begin
                wr_addr = op1_r;
                wr_val = op2_r;
            end else if (ir_r[7:1] == `P_DIR_IND) begin
                wr_addr = op1_r;
                wr_val = ind_val;
            end else if (ir_r[7:3] == `G_DIR_RN) begin
                wr_addr = op1_r;
                wr_val = rn_val;
            end else if (ir_r == `OP_DIR_DIR) begin
                wr_addr = op2_r;
                wr_val = dir_val;
            end else begin
                wr_go = 1'b0;
            end
        end else if (state_r == S_PU1 || state_r == S_PU2) begin
            wr_ind = 1'b1;
            wr_addr = (state_r == S_PU1) ? sp_r + 8'h01 : sp_r + 8'h02;
            wr_val = (state_r == S_PU1) ? pc_r[7:0] : pc_r[15:8];
        end else if (state_r == S_CD) begin
            wr_val = code_data;
        end else if (state_r == S_XE && !x_wr) begin
            wr_val = lo_s2_r;
        end else begin
            wr_go = 1'b0;
        end
    end

    // Internal RAM write; the array carries no reset.
    always @(posedge clk) begin
        if (ram_we) begin
            iram[wr_addr] <= wr_val;
        end
    end

    bmmd_prod #(.W(8)) u_prod (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(prod_go_r),
        .mcand(acc_r),
        .mplier(b_r),
        .prod(prod),
        .done(prod_done)
    );

    // Sequencer, architectural registers and external bus pins.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= S_FA;
            pc_r <= 16'h0000;
            code_addr_r <= 16'h0000;
            ir_r <= 8'h00;
            op1_r <= 8'h00;
            op2_r <= 8'h00;
            idx_r <= 2'd0;
            cnt_r <= 8'h00;
            xcnt_r <= 3'h0;
            acc_r <= 8'h00;
            b_r <= 8'h00;
            psw_r <= 8'h00;
            sp_r <= `SP_RST;
            dp_r <= 16'h0000;
            lo_port_out_r <= `LO_PORT_RST;
            lo_port_oe_n_r <= 1'b1;
            hi_port_out_r <= `HI_PORT_RST;
            addr_latch_r <= 1'b0;
            ext_rd_n_r <= 1'b1;
            ext_wr_n_r <= 1'b1;
            lo_s1_r <= 8'h00;
            lo_s2_r <= 8'h00;
            prod_go_r <= 1'b0;
        end else begin
            lo_s1_r <= lo_port_in;
            lo_s2_r <= lo_s1_r;
            cnt_r <= cnt_r + 8'h01;
            prod_go_r <= 1'b0;
            if (sfr_we) begin
                case (wr_addr)
                    `SFR_ACC: acc_r <= wr_val;
                    `SFR_B: b_r <= wr_val;
                    `SFR_PSW: psw_r <= wr_val;
                    `SFR_SP: sp_r <= wr_val;
                    `SFR_DPL: dp_r[7:0] <= wr_val;
                    `SFR_DPH: dp_r[15:8] <= wr_val;
                    `SFR_HI_PORT: hi_port_out_r <= wr_val;
                    default: ;
                endcase
            end
            case (state_r)
                S_FA: begin
                    code_addr_r <= pc_r;
                    pc_r <= pc_r + 16'h0001;
                    state_r <= S_FD;
                end
                S_FD: begin
                    case (idx_r)
                        2'd0: ir_r <= code_data;
                        2'd1: op1_r <= code_data;
                        default: op2_r <= code_data;
                    endcase
                    idx_r <= idx_r + 2'd1;
                    state_r <= (idx_r + 2'd1 == fetch_len) ? S_EX : S_FA;
                end
                S_EX: begin
                    state_r <= S_WT;
                    if (ir_r == `OP_BR_ZERO) begin
                        if (acc_r == 8'h00) begin
                            pc_r <= pc_r + {{8{op1_r[7]}}, op1_r};
                        end
                    end else if (ir_r == `OP_CALL_LONG) begin
                        state_r <= S_PU1;
                    end else if (ir_r == `OP_JUMP_LONG) begin
                        pc_r <= {op1_r, op2_r};
                    end else if (ir_r == `OP_C_BIT) begin
                        psw_r[`PSW_CY] <= dir_val[op1_r[2:0]];
                    end else if (ir_r == `OP_DP_IMM) begin
                        dp_r <= {op1_r, op2_r};
                    end else if (ir_r == `OP_CODE_DP) begin
                        code_addr_r <= dp_r + {8'h00, acc_r};
                        state_r <= S_CD;
                    end else if (ir_r == `OP_CODE_PC) begin
                        code_addr_r <= pc_r + {8'h00, acc_r};
                        state_r <= S_CD;
                    end else if (ir_r == `OP_PRODUCT) begin
                        prod_go_r <= 1'b1;
                        state_r <= S_MU;
                    end else if (x_any) begin
                        lo_port_out_r <= x_dp ? dp_r[7:0] : ri_val;
                        lo_port_oe_n_r <= 1'b0;
                        addr_latch_r <= 1'b1;
                        if (x_dp) begin
                            hi_port_out_r <= dp_r[15:8];
                        end
                        xcnt_r <= 3'h0;
                        state_r <= S_XS;
                    end
                end
                S_PU1: begin
                    state_r <= S_PU2;
                end
                S_PU2: begin
                    sp_r <= sp_r + 8'h02;
                    pc_r <= {op1_r, op2_r};
                    state_r <= S_WT;
                end
                S_CD: begin
                    state_r <= S_WT;
                end
                S_MU: begin
                    if (prod_done) begin
                        acc_r <= prod[7:0];
                        b_r <= prod[15:8];
                        psw_r[`PSW_CY] <= 1'b0;
                        psw_r[`PSW_WIDE] <= (prod[15:8] != 8'h00);
                        state_r <= S_WT;
                    end
                end
                S_XS: begin
                    xcnt_r <= xcnt_r + 3'h1;
                    if (xcnt_r == `XSTRB_CLKS) begin
                        state_r <= S_XE;
                    end else if (xcnt_r == 3'h0) begin
                        addr_latch_r <= 1'b0;
                    end else if (x_wr) begin
                        lo_port_out_r <= acc_r;
                        ext_wr_n_r <= 1'b0;
                    end else begin
                        lo_port_oe_n_r <= 1'b1;
                        ext_rd_n_r <= 1'b0;
                    end
                end
                S_XE: begin
                    ext_wr_n_r <= 1'b1;
                    ext_rd_n_r <= 1'b1;
                    lo_port_oe_n_r <= 1'b1;
                    state_r <= S_WT;
                end
                S_WT: begin
                    // Pads every instruction to its machine cycles; no-op ends here too.
                    if (cnt_r >= total_clks - 8'h01) begin
                        state_r <= S_FA;
                        cnt_r <= 8'h00;
                        idx_r <= 2'd0;
                    end
                end
                default: begin
                    state_r <= S_FA;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> hdl/_unused_placeholder_none.v
// Intentionally minimal helper-free file holding no logic.
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// >>> testbench/bmmd_props.sv
// Assertions on the external bus pins and accumulator of the decode block.
`timescale 1ns/100ps
`default_nettype none
module bmmd_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] lo_port_in,
    input wire logic [7:0] lo_port_out,
    input wire logic lo_port_oe_n,
    input wire logic [7:0] hi_port_out,
    input wire logic addr_latch,
    input wire logic ext_rd_n,
    input wire logic ext_wr_n,
    input wire logic [7:0] acc_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Each strobe is low for four clocks and then returns high.
    sequence s_rd_low;
        (!ext_rd_n) [*4] ##1 ext_rd_n;
    endsequence
    sequence s_wr_low;
        (!ext_wr_n) [*4] ##1 ext_wr_n;
    endsequence
    property p_rd_len;
        $fell(ext_rd_n) |-> s_rd_low;
    endproperty
    property p_wr_len;
        $fell(ext_wr_n) |-> s_wr_low;
    endproperty
    property p_latch_strobe;
        $rose(addr_latch) |=> !addr_latch ##1 ($fell(ext_rd_n) || $fell(ext_wr_n));
    endproperty
    property p_addr_drive;
        addr_latch |-> !lo_port_oe_n;
    endproperty
    property p_wr_drive;
        !ext_wr_n |-> !lo_port_oe_n && lo_port_out == acc_out;
    endproperty
    property p_rd_float;
        !ext_rd_n |-> lo_port_oe_n;
    endproperty
    property p_excl;
        ext_rd_n || ext_wr_n;
    endproperty
    property p_hi_hold;
        (!ext_rd_n || !ext_wr_n) |-> $stable(hi_port_out);
    endproperty
    property p_rd_acc;
        $rose(ext_rd_n) |-> acc_out == $past(lo_port_in, 3);
    endproperty
    a_rd_len: assert property (p_rd_len) else $error("read strobe length wrong");
    a_wr_len: assert property (p_wr_len) else $error("write strobe length wrong");
    a_latch_strobe: assert property (p_latch_strobe) else $error("latch pulse or strobe start wrong");
    a_addr_drive: assert property (p_addr_drive) else $error("address not driven at latch");
    a_wr_drive: assert property (p_wr_drive) else $error("write data not accumulator");
    a_rd_float: assert property (p_rd_float) else $error("low port driven during read");
    a_excl: assert property (p_excl) else $error("both strobes low");
    a_hi_hold: assert property (p_hi_hold) else $error("high port moved during strobe");
    a_rd_acc: assert property (p_rd_acc) else $error("read data not in accumulator");
endmodule
bind bmmd_core bmmd_props u_props (.clk(clk), .sys_rst(sys_rst), .lo_port_in(lo_port_in),
    .lo_port_out(lo_port_out), .lo_port_oe_n(lo_port_oe_n), .hi_port_out(hi_port_out),
    .addr_latch(addr_latch), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .acc_out(acc_out));
`default_nettype wire

// >>> testbench/bmmd_ext_model.sv
// Code memory and external data memory as seen across the port pins.
`timescale 1ns/100ps
`default_nettype none
module bmmd_ext_model (
    input wire logic clk,
    input wire logic [15:0] code_addr,
    output logic [7:0] code_data,
    input wire logic [7:0] lo_port_out,
    input wire logic lo_port_oe_n,
    input wire logic [7:0] hi_port_out,
    input wire logic addr_latch,
    input wire logic ext_rd_n,
    input wire logic ext_wr_n,
    output logic [7:0] lo_port_in
);
    logic [7:0] rom [0:511];
    logic [7:0] mem [0:65535];
    logic [15:0] addr_r;
    logic [7:0] last_r = 8'h00;
    // Code memory answers combinationally.
    assign code_data = rom[code_addr[8:0]];
    // Address is caught while the latch is high, write data while the strobe is low.
    always @(posedge clk) begin
        if (addr_latch) begin
            addr_r <= {hi_port_out, lo_port_out};
        end
        if (!ext_wr_n) begin
            mem[addr_r] <= lo_port_out;
        end
        last_r <= lo_port_in;
    end
    // Pin level: the device, the memory during a read, else a value that keeps toggling.
    assign lo_port_in = !lo_port_oe_n ? lo_port_out : (!ext_rd_n ? mem[addr_r] : ~last_r);
endmodule
`default_nettype wire

// >>> testbench/bmmd_bench.sv
// Self-checking bench running small programs through the decode block.
`timescale 1ns/100ps
`default_nettype none
module bmmd_bench;
    localparam int MC = 8;
    logic clk, sys_rst, lo_port_oe_n, addr_latch, ext_rd_n, ext_wr_n;
    logic [15:0] code_addr, pc_out;
    logic [7:0] code_data, lo_port_in, lo_port_out, hi_port_out, acc_out;
    int fails = 0;
    int samples_checked = 0;
    bmmd_core #(.MC_CLKS(MC)) DUT (.clk(clk), .sys_rst(sys_rst), .code_addr(code_addr), .code_data(code_data),
        .lo_port_in(lo_port_in), .lo_port_out(lo_port_out), .lo_port_oe_n(lo_port_oe_n), .hi_port_out(hi_port_out),
        .addr_latch(addr_latch), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .pc_out(pc_out), .acc_out(acc_out));
    bmmd_ext_model u_mem (.clk(clk), .code_addr(code_addr), .code_data(code_data), .lo_port_out(lo_port_out),
        .lo_port_oe_n(lo_port_oe_n), .hi_port_out(hi_port_out), .addr_latch(addr_latch), .ext_rd_n(ext_rd_n),
        .ext_wr_n(ext_wr_n), .lo_port_in(lo_port_in));
    // Free-running core clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic conclude;
        $display("Comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic put(input int base, input logic [7:0] b [$]);
        foreach (b[i]) u_mem.rom[base + i] = b[i];
    endtask
    // Holds the block in reset and clears code memory to idle bytes.
    task automatic boot;
        @(negedge clk);
        sys_rst = 1'b1;
        for (int i = 0; i < 512; i++) u_mem.rom[i] = 8'h00;
        put(16'h00F0, '{8'h02, 8'h00, 8'hF0});
    endtask
    task automatic go;
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
    endtask
    // Waits, bounded, for the program counter to show an address.
    task automatic wait_pc(input logic [15:0] a);
        int n;
        n = 0;
        while (pc_out !== a && n < 3000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 3000) begin
            fails++;
            $display("BAD %0t program counter never reached %h", $time, a);
        end
    endtask
    task automatic at(input logic [15:0] a, input logic [7:0] exp);
        wait_pc(a);
        check({8'h00, acc_out}, {8'h00, exp});
    endtask
    // Counts clocks from one fetch start to the next and compares with whole machine cycles.
    task automatic span(input logic [15:0] a, input logic [15:0] b, input int cyc);
        int n;
        wait_pc(a);
        n = 0;
        while (pc_out !== b && n < 500) begin
            @(negedge clk);
            n++;
        end
        check(16'(n), 16'(cyc * MC));
    endtask
    task automatic sc_regs;
        boot();
        for (int n = 0; n < 8; n++) begin
            u_mem.rom[2 * n] = 8'h78 | 8'(n);
            u_mem.rom[2 * n + 1] = 8'h30 | 8'(n);
            u_mem.rom[16 + 2 * n] = 8'hE8 | 8'(n);
        end
        go();
        for (int n = 0; n < 8; n++) begin
            at(16'(18 + 2 * n), 8'h30 | 8'(n));
            if (n == 0) span(16'h0012, 16'h0013, 1);
        end
    endtask
    task automatic sc_chain;
        boot();
        put(0, '{8'h75, 8'h40, 8'hC3, 8'h85, 8'h40, 8'h41, 8'hAA, 8'h41, 8'h8A, 8'h42, 8'h78, 8'h42, 8'hE6, 8'hFD,
            8'h74, 8'h11, 8'hED, 8'hF5, 8'h43, 8'h74, 8'h22, 8'hF6, 8'h79, 8'h42, 8'hE7, 8'h76, 8'h5E, 8'hE5, 8'h43,
            8'hE6, 8'h74, 8'h77, 8'hA6, 8'hE0, 8'h74, 8'h00, 8'h87, 8'h45, 8'hE5, 8'h45});
        go();
        at(16'h000E, 8'hC3);
        at(16'h0012, 8'hC3);
        at(16'h001A, 8'h22);
        at(16'h001E, 8'hC3);
        at(16'h001F, 8'h5E);
        at(16'h00F3, 8'h77);
    endtask
    task automatic sc_branch;
        boot();
        put(0, '{8'h02, 8'h00, 8'h10, 8'h74, 8'h5C, 8'h02, 8'h00, 8'hF0});
        put(16, '{8'h74, 8'h00, 8'h60, 8'h05, 8'h74, 8'hEE, 8'h02, 8'h00, 8'hF0, 8'h74, 8'h33, 8'h60, 8'hF6,
            8'h74, 8'h00, 8'h60, 8'hE2});
        go();
        at(16'h001E, 8'h33);
        at(16'h00F3, 8'h5C);
    endtask
    task automatic sc_call;
        boot();
        put(0, '{8'h02, 8'h01, 8'h00});
        put(256, '{8'h12, 8'h00, 8'h20});
        put(32, '{8'hE5, 8'h08, 8'hE5, 8'h09, 8'hE5, 8'h81});
        go();
        at(16'h0023, 8'h03);
        at(16'h0025, 8'h01);
        at(16'h00F3, 8'h09);
    endtask
    task automatic sc_table;
        boot();
        put(0, '{8'h90, 8'h01, 8'h80, 8'h74, 8'h05, 8'h93, 8'h74, 8'h02, 8'h83, 8'h02, 8'h00, 8'hF0});
        put(16'h0185, '{8'hA7});
        go();
        at(16'h0007, 8'hA7);
        at(16'h00F3, 8'hF0);
    endtask
    task automatic sc_xmem;
        boot();
        put(0, '{8'h90, 8'h12, 8'h34, 8'h74, 8'h6D, 8'hF0, 8'h74, 8'h00, 8'hE0, 8'h78, 8'h56, 8'h74, 8'h9A,
            8'hF2, 8'h74, 8'h00, 8'hE2});
        go();
        check({8'h00, hi_port_out}, 16'h00FF);
        at(16'h000A, 8'h6D);
        check({8'h00, hi_port_out}, 16'h0012);
        at(16'h00F3, 8'h9A);
        check({8'h00, hi_port_out}, 16'h0012);
        check({8'h00, u_mem.mem[16'h1234]}, 16'h006D);
        check({8'h00, u_mem.mem[16'h1256]}, 16'h009A);
    endtask
    task automatic sc_product;
        boot();
        put(0, '{8'h75, 8'h20, 8'h01, 8'h75, 8'h21, 8'h00, 8'hA2, 8'h00, 8'h92, 8'h08, 8'hE5, 8'h21, 8'hE5, 8'hD0,
            8'h75, 8'hF0, 8'hFF, 8'h74, 8'hFF, 8'hA4, 8'hE5, 8'hF0, 8'hE5, 8'hD0, 8'h75, 8'hF0, 8'h0C, 8'h74, 8'h15,
            8'hA4, 8'hE5, 8'hD0});
        go();
        at(16'h000D, 8'h01);
        at(16'h000F, 8'h80);
        span(16'h0014, 16'h0015, 4);
        at(16'h0015, 8'h01);
        at(16'h0017, 8'hFE);
        at(16'h0019, 8'h04);
        at(16'h001F, 8'hFC);
        at(16'h00F3, 8'h00);
    endtask
    // Runs every scenario in turn; each resets the block first.
    initial begin
        sys_rst = 1'b1;
        sc_regs();
        sc_chain();
        sc_branch();
        sc_call();
        sc_table();
        sc_xmem();
        sc_product();
        conclude();
    end
    // Watchdog sized for seven programs of under two thousand clocks each.
    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        conclude();
    end
endmodule
`default_nettype wire
